// ==== shared/sgmii_auto_negotiation_regs.svh ====
// Register offsets, field positions, reset values and timing counts
// for the partner status and event block. Included by bare name.
`ifndef SGMII_AUTO_NEGOTIATION_REGS_SVH
`define SGMII_AUTO_NEGOTIATION_REGS_SVH

// Register offsets on the plain register port
`define OFS_PARTNER_ABILITY 16'hd30a
`define OFS_EVENT_STATUS 16'hd30b
`define OFS_EVENT_MASK 16'hd30c
`define OFS_NEG_CONTROL 16'hd320
`define OFS_TX_PAGE 16'hd321

// Reset values
`define RST_PARTNER_ABILITY 7'h00
`define RST_EVENT_STATUS 5'h00
`define RST_EVENT_MASK 5'h1f
`define RST_TX_PAGE 16'h0000

// Event bit positions
`define EVT_SIGNAL_LOSS 4
`define EVT_SYNC_STATE 3
`define EVT_LINK_STATE 2
`define EVT_LATER_PAGE 1
`define EVT_FIRST_PAGE 0

// Control bit positions
`define CTL_ABILITY_OVERRIDE 0
`define CTL_AUTO_NEG 1

// Next page flag inside the transmit page
`define NEXT_PAGE_FLAG_BIT 15

// Negotiation timer
`define LINK_TIME_NS 1600000
`define CLK_PERIOD_NS 25

`endif

// ==== shared/sgmii_auto_negotiation_pkg.sv ====
// Types for the partner status and event block.
// Constants live in the _regs header; this holds types only.
package sgmii_auto_negotiation_pkg;

    // Gray coded along idle, complete, wait
    typedef enum logic [1:0] {
        IDLE_DETECT = 2'b00,
        COMPLETE_ACK = 2'b01,
        NEXT_PAGE_WAIT = 2'b11
    } neg_state_type;

    typedef struct packed {
        logic prev;
        logic primed;
    } change_state_type;

    typedef struct packed {
        neg_state_type neg;
        logic [16:0] timer;
        logic lastWasNext;
        logic freshPage;
        logic [15:0] txPage;
        logic abilityOverride;
        logic autoNegSw;
        logic [6:0] ability;
        logic [4:0] evt;
        logic [4:0] mask;
        logic [15:0] rdData;
    } core_state_type;

endpackage : sgmii_auto_negotiation_pkg

// ==== logic/signal_change.sv ====
// Flags any change of a synchronous level after the first sample out of reset as a one-cycle pulse.
// Assumes the level is already in the clk domain.
`timescale 1ns/1ps
module signal_change (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Watched level and change pulse
    input wire logic level,
    output logic change
);

    sgmii_auto_negotiation_pkg::change_state_type s;
    sgmii_auto_negotiation_pkg::change_state_type next_s;

    // Quiet until one sample is held, so reset gives no false edge
    always_comb begin
        next_s = s;
        next_s.prev = level;
        next_s.primed = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Either direction counts
    assign change = s.primed && (level != s.prev);

endmodule : signal_change

// ==== logic/sgmii_auto_negotiation_partner_status_irq.sv ====
// Partner ability status, event latches, mask and interrupt, plus the
// completion end of the negotiation machine.
// Assumes all inputs synchronous to clk; one received page per pulse.
`timescale 1ns/1ps
`include "sgmii_auto_negotiation_regs.svh"
module sgmii_auto_negotiation_partner_status_irq #(
    parameter int linkTimerCycles = `LINK_TIME_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [15:0] rdData,
    // Line state from the receive path
    input wire logic signalLoss,
    input wire logic syncOk,
    input wire logic linkOk,
    // Received pages, their format and the hardware enable from the negotiation core
    input wire logic pageRcvd,
    input wire logic [15:0] rxPage,
    input wire logic sgmiiMode,
    input wire logic autoNegHw,
    // Outputs
    output logic [15:0] txPage,
    output logic [1:0] negState,
    output logic [6:0] partnerAbility,
    output logic irq
);

    localparam logic [16:0] TIMER_LAST = 17'(linkTimerCycles - 1);

    sgmii_auto_negotiation_pkg::core_state_type s;
    sgmii_auto_negotiation_pkg::core_state_type next_s;

    logic lossChange;
    logic syncChange;
    logic linkChange;
    logic wrAbility;
    logic wrEvent;
    logic wrMask;
    logic wrControl;
    logic wrTxPage;
    logic negEnabled;
    logic resolve;
    logic enterNext;
    logic enterFirst;
    logic timerDone;
    logic [1:0] decRate;
    logic [1:0] decFault;
    logic [1:0] decPause;
    logic decDuplex;
    logic [4:0] evtSet;
    logic [15:0] rdValue;

    // Change detectors for the three line levels
    signal_change u_loss (
        .clk(clk),
        .rstn(rstn),
        .level(signalLoss),
        .change(lossChange)
    );

    signal_change u_sync (
        .clk(clk),
        .rstn(rstn),
        .level(syncOk),
        .change(syncChange)
    );

    signal_change u_link (
        .clk(clk),
        .rstn(rstn),
        .level(linkOk),
        .change(linkChange)
    );

    // Write decode
    always_comb begin
        wrAbility = 1'b0;
        wrEvent = 1'b0;
        wrMask = 1'b0;
        wrControl = 1'b0;
        wrTxPage = 1'b0;
        if (wrStrobe && addr == `OFS_PARTNER_ABILITY) begin
            wrAbility = 1'b1;
        end else if (wrStrobe && addr == `OFS_EVENT_STATUS) begin
            wrEvent = 1'b1;
        end else if (wrStrobe && addr == `OFS_EVENT_MASK) begin
            wrMask = 1'b1;
        end else if (wrStrobe && addr == `OFS_NEG_CONTROL) begin
            wrControl = 1'b1;
        end else if (wrStrobe && addr == `OFS_TX_PAGE) begin
            wrTxPage = 1'b1;
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rdValue = 16'h0000;
        if (addr == `OFS_PARTNER_ABILITY) begin
            rdValue = {9'h000, s.ability};
        end else if (addr == `OFS_EVENT_STATUS) begin
            rdValue = {11'h000, s.evt};
        end else if (addr == `OFS_EVENT_MASK) begin
            rdValue = {11'h000, s.mask};
        end else if (addr == `OFS_NEG_CONTROL) begin
            rdValue = {12'h000, s.neg, s.autoNegSw, s.abilityOverride};
        end else if (addr == `OFS_TX_PAGE) begin
            rdValue = s.txPage;
        end
    end

    // Page decode: serial gigabit page or plain gigabit page
    always_comb begin
        if (sgmiiMode) begin
            decRate = rxPage[11:10];
            decFault = {1'b0, ~rxPage[15]};
            decPause = 2'b00;
            decDuplex = rxPage[12];
        end else begin
            decRate = 2'b11;
            decFault = rxPage[13:12];
            decPause = rxPage[8:7];
            decDuplex = rxPage[5];
        end
    end

    // Machine events and resolution qualifier
    assign negEnabled = s.autoNegSw || autoNegHw;
    assign enterFirst = pageRcvd && s.neg == sgmii_auto_negotiation_pkg::IDLE_DETECT;
    assign enterNext = pageRcvd && s.neg == sgmii_auto_negotiation_pkg::NEXT_PAGE_WAIT;
    assign resolve = enterFirst && negEnabled && !s.abilityOverride;
    assign timerDone = s.timer == TIMER_LAST;

    // Event sources, one bit each
    always_comb begin
        evtSet = 5'h00;
        evtSet[`EVT_SIGNAL_LOSS] = lossChange;
        evtSet[`EVT_SYNC_STATE] = syncChange;
        evtSet[`EVT_LINK_STATE] = linkChange;
        evtSet[`EVT_LATER_PAGE] = enterNext && negEnabled;
        evtSet[`EVT_FIRST_PAGE] = enterFirst && negEnabled;
    end

    // Next state of everything
    always_comb begin
        next_s = s;
        next_s.rdData = rdStrobe ? rdValue : 16'h0000;
        if (wrControl) begin
            next_s.abilityOverride = wrData[`CTL_ABILITY_OVERRIDE];
            next_s.autoNegSw = wrData[`CTL_AUTO_NEG];
        end
        if (wrMask) begin
            next_s.mask = wrData[4:0];
        end
        // Write one clears, a new event in the same cycle wins
        next_s.evt = (s.evt & ~(wrEvent ? wrData[4:0] : 5'h00)) | evtSet;
        // Software value stands until the next resolution
        if (wrAbility) begin
            next_s.ability = wrData[6:0];
        end
        if (resolve) begin
            next_s.ability = {decRate, decFault, decPause, decDuplex};
        end
        // A consumed page is no longer fresh; a write in the same cycle wins
        case (s.neg)
            sgmii_auto_negotiation_pkg::IDLE_DETECT: begin
                next_s.timer = 17'h00000;
                if (enterFirst && negEnabled) begin
                    next_s.neg = sgmii_auto_negotiation_pkg::COMPLETE_ACK;
                    next_s.lastWasNext = 1'b0;
                    next_s.freshPage = 1'b0;
                end
            end
            sgmii_auto_negotiation_pkg::COMPLETE_ACK: begin
                next_s.timer = s.timer + 17'h00001;
                if (s.freshPage && s.txPage[`NEXT_PAGE_FLAG_BIT]) begin
                    next_s.neg = sgmii_auto_negotiation_pkg::NEXT_PAGE_WAIT;
                    next_s.freshPage = 1'b0;
                end else if (timerDone) begin
                    next_s.neg = sgmii_auto_negotiation_pkg::IDLE_DETECT;
                end
            end
            sgmii_auto_negotiation_pkg::NEXT_PAGE_WAIT: begin
                next_s.timer = 17'h00000;
                if (enterNext && negEnabled) begin
                    next_s.neg = sgmii_auto_negotiation_pkg::COMPLETE_ACK;
                    next_s.lastWasNext = 1'b1;
                    next_s.freshPage = 1'b0;
                end
            end
            default: begin
                next_s.neg = sgmii_auto_negotiation_pkg::IDLE_DETECT;
            end
        endcase
        // Dropping negotiation abandons any exchange in flight
        if (!negEnabled) begin
            next_s.neg = sgmii_auto_negotiation_pkg::IDLE_DETECT;
        end
        if (wrTxPage) begin
            next_s.txPage = wrData;
            next_s.freshPage = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s.neg <= sgmii_auto_negotiation_pkg::IDLE_DETECT;
            s.timer <= 17'h00000;
            s.lastWasNext <= 1'b0;
            s.freshPage <= 1'b0;
            s.txPage <= `RST_TX_PAGE;
            s.abilityOverride <= 1'b0;
            s.autoNegSw <= 1'b0;
            s.ability <= `RST_PARTNER_ABILITY;
            s.evt <= `RST_EVENT_STATUS;
            s.mask <= `RST_EVENT_MASK;
            s.rdData <= 16'h0000;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign rdData = s.rdData;
    assign txPage = s.txPage;
    assign negState = s.neg;
    assign partnerAbility = s.ability;
    assign irq = |(s.evt & ~s.mask);

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_rate;
        resolve |=> s.ability[6:5] == ($past(sgmiiMode) ? $past(rxPage[11:10]) : 2'b11);
    endproperty
    a_rate: assert property (p_rate) else $error("partner rate not resolved");

    property p_hold;
        (s.abilityOverride || !negEnabled) && !wrAbility |=> $stable(s.ability);
    endproperty
    a_hold: assert property (p_hold) else $error("ability changed while held");

    property p_fault;
        resolve && sgmiiMode |=> s.ability[4:3] == {1'b0, !$past(rxPage[15])};
    endproperty
    a_fault: assert property (p_fault) else $error("fault code wrong");

    property p_pause;
        resolve && !sgmiiMode |=> s.ability[2:1] == $past(rxPage[8:7]);
    endproperty
    a_pause: assert property (p_pause) else $error("pause code wrong");

    property p_duplex;
        resolve |=> s.ability[0]
            == ($past(sgmiiMode) ? $past(rxPage[12]) : $past(rxPage[5]));
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex wrong");

    property p_loss;
        // The detector is blind in the first cycle out of reset
        $changed(signalLoss) && $past(rstn) ##1 (1'b1) |-> s.evt[`EVT_SIGNAL_LOSS];
    endproperty
    a_loss: assert property (p_loss) else $error("loss change not latched");

    property p_sync;
        syncChange |=> s.evt[`EVT_SYNC_STATE];
    endproperty
    a_sync: assert property (p_sync) else $error("sync change not latched");

    property p_link;
        linkChange |=> s.evt[`EVT_LINK_STATE];
    endproperty
    a_link: assert property (p_link) else $error("link change not latched");

    property p_later;
        enterNext && negEnabled |=> s.evt[`EVT_LATER_PAGE] && s.lastWasNext;
    endproperty
    a_later: assert property (p_later) else $error("next page not flagged");

    property p_first;
        enterFirst && negEnabled |=> s.evt[`EVT_FIRST_PAGE] && !s.lastWasNext;
    endproperty
    a_first: assert property (p_first) else $error("base page not flagged");

    property p_expire;
        s.neg == sgmii_auto_negotiation_pkg::COMPLETE_ACK && timerDone && !s.freshPage
            |=> s.neg == sgmii_auto_negotiation_pkg::IDLE_DETECT;
    endproperty
    a_expire: assert property (p_expire) else $error("no return to idle");

    property p_sticky;
        !wrEvent |=> (s.evt & $past(s.evt)) == $past(s.evt);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event dropped");

    property p_irq;
        |($past(evtSet) & s.mask) == 1'b0 && $past(evtSet) != 5'h00 |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked event gave no irq");

endmodule : sgmii_auto_negotiation_partner_status_irq

// ==== verif/link_partner_model.sv ====
// Remote link partner: hands over one received page per bench request.
// Assumes requests arrive just after a rising edge of clk.
`timescale 1ns/1ps
module link_partner_model (
    // Clock
    input wire logic clk,
    // Request from the bench
    input wire logic send,
    input wire logic [15:0] page,
    // Toward the block
    output logic pageRcvd,
    output logic [15:0] rxPage
);
    initial begin
        pageRcvd = 1'b0;
        rxPage = 16'h0000;
    end
    // Word toggles outside the pulse so a stale page is never trusted
    always @(posedge clk) begin
        pageRcvd <= send;
        rxPage <= send ? page : ~rxPage;
    end
endmodule : link_partner_model

// ==== verif/sgmii_auto_negotiation_partner_status_irq_tb_top.sv ====
// Self-checking bench for the partner status and event block.
// Assumes a short negotiation timer; reads are checked by a monitor.
`timescale 1ns/1ps
`include "sgmii_auto_negotiation_regs.svh"
module sgmii_auto_negotiation_partner_status_irq_tb_top;
    localparam int timerCycles = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic signalLoss = 1'b0;
    logic syncOk = 1'b0;
    logic linkOk = 1'b0;
    logic sgmiiMode = 1'b0;
    logic autoNegHw = 1'b0;
    logic send = 1'b0;
    logic rdPend = 1'b0;
    logic pageRcvd, irq;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wrData = 16'h0000;
    logic [15:0] page = 16'h0000;
    logic [15:0] rdData, rxPage, txPage, pg;
    logic [1:0] negState;
    logic [6:0] partnerAbility;
    logic [15:0] expQ[$];
    int n_fail = 0;
    int comparisons = 0;

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    sgmii_auto_negotiation_partner_status_irq #(.linkTimerCycles(timerCycles)) i_dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .signalLoss(signalLoss), .syncOk(syncOk), .linkOk(linkOk),
        .pageRcvd(pageRcvd), .rxPage(rxPage), .sgmiiMode(sgmiiMode),
        .autoNegHw(autoNegHw), .txPage(txPage), .negState(negState),
        .partnerAbility(partnerAbility), .irq(irq));

    link_partner_model i_partner (
        .clk(clk), .send(send), .page(page), .pageRcvd(pageRcvd), .rxPage(rxPage));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // Expected ability word for a base page
    function automatic logic [15:0] abl(input logic s, input logic [15:0] p);
        abl = s ? {9'h000, p[11:10], 1'b0, ~p[15], 2'b00, p[12]}
                : {9'h000, 2'b11, p[13:12], p[8:7], p[5]};
    endfunction : abl

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        expQ.push_back(exp);
        @(posedge clk);
        rdStrobe <= 1'b0;
    endtask : rd

    // Lets the edge's updates land before outputs are looked at
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic xfer(input logic [15:0] p);
        @(posedge clk);
        send <= 1'b1;
        page <= p;
        @(posedge clk);
        send <= 1'b0;
        tick(3);
    endtask : xfer

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rdPend) check(rdData, expQ.pop_front());
        rdPend <= rdStrobe;
    end

    initial begin
        #(25ns * 4000);
        n_fail++;
        finish_test();
    end

    initial begin
        void'($urandom(84216));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(`OFS_PARTNER_ABILITY, 16'h0000);
        rd(`OFS_EVENT_STATUS, 16'h0000);
        rd(`OFS_EVENT_MASK, 16'h001f);
        rd(16'hd30f, 16'h0000);
        $display("Test reset done");
        // Line events while still masked
        signalLoss <= 1'b1;
        syncOk <= 1'b1;
        linkOk <= 1'b1;
        tick(3);
        check(irq, 16'h0000);
        rd(`OFS_EVENT_STATUS, 16'h001c);
        wr(`OFS_EVENT_MASK, 16'h0000);
        tick(1);
        check(irq, 16'h0001);
        wr(`OFS_EVENT_STATUS, 16'h0004);
        wr(`OFS_EVENT_STATUS, 16'h0000);
        rd(`OFS_EVENT_STATUS, 16'h0018);
        linkOk <= 1'b0;
        tick(3);
        rd(`OFS_EVENT_STATUS, 16'h001c);
        wr(`OFS_EVENT_MASK, 16'h0003);
        wr(`OFS_EVENT_STATUS, 16'h001f);
        tick(1);
        check(irq, 16'h0000);
        $display("Test line events done");
        // Base pages in both formats, every rate code
        wr(`OFS_NEG_CONTROL, 16'h0002);
        for (int i = 0; i < 8; i++) begin
            pg = 16'($urandom);
            pg[11:10] = 2'(i);
            @(posedge clk);
            sgmiiMode <= i[2];
            xfer(pg);
            check(negState, 16'h0001);
            check(partnerAbility, abl(i[2], pg));
            rd(`OFS_EVENT_STATUS, 16'h0001);
            rd(`OFS_PARTNER_ABILITY, abl(i[2], pg));
            wr(`OFS_EVENT_STATUS, 16'h0001);
            // Eight cycles spent since entry; still waiting in the last timer cycle
            tick(timerCycles - 9);
            check(negState, 16'h0001);
            tick(1);
            check(negState, 16'h0000);
        end
        $display("Test base pages done");
        // Next page requested in time, partner answers
        xfer(16'h1234);
        wr(`OFS_TX_PAGE, 16'h8000);
        tick(3);
        check(negState, 16'h0003);
        check(txPage, 16'h8000);
        xfer(16'h0000);
        check(negState, 16'h0001);
        rd(`OFS_EVENT_STATUS, 16'h0003);
        rd(`OFS_PARTNER_ABILITY, abl(1'b1, 16'h1234));
        tick(timerCycles);
        $display("Test next page done");
        // Override keeps the software value, then hardware wins again
        wr(`OFS_NEG_CONTROL, 16'h0003);
        wr(`OFS_PARTNER_ABILITY, 16'h0055);
        xfer(16'hffff);
        rd(`OFS_PARTNER_ABILITY, 16'h0055);
        tick(timerCycles);
        wr(`OFS_NEG_CONTROL, 16'h0002);
        xfer(pg);
        rd(`OFS_PARTNER_ABILITY, abl(1'b1, pg));
        tick(timerCycles);
        // No enable at all, then hardware enable alone
        wr(`OFS_NEG_CONTROL, 16'h0000);
        xfer(pg);
        check(negState, 16'h0000);
        @(posedge clk);
        autoNegHw <= 1'b1;
        xfer(pg);
        check(negState, 16'h0001);
        $display("Test enables done");
        tick(2);
        finish_test();
    end
endmodule : sgmii_auto_negotiation_partner_status_irq_tb_top
